// >>> verilog/clock_accuracy_monitor_pkg.sv
// Package: register map, field layout, reset values and encodings of the clock accuracy monitor
package clock_accuracy_monitor_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W = 16;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_TARGET_CTRL = 8'h00;
  localparam logic [7:0] OFS_REFERENCE_CTRL = 8'h04;
  localparam logic [7:0] OFS_MODULE_STOP = 8'h08;
  localparam logic [7:0] OFS_UPPER_LIMIT = 8'h0C;
  localparam logic [7:0] OFS_LOWER_LIMIT = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned TGT_EN_BIT = 0;
  localparam int unsigned TGT_SEL_LSB = 1;
  localparam int unsigned REF_EXT_BIT = 0;
  localparam int unsigned REF_SEL_LSB = 1;
  localparam int unsigned REF_FILT_BIT = 4;
  localparam int unsigned STOP_BIT = 0;
  localparam int unsigned ST_END_BIT = 0;
  localparam int unsigned ST_FERR_BIT = 1;
  localparam int unsigned ST_OVF_BIT = 2;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned EVT_W = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_TARGET_CTRL = 8'h00;
  localparam logic [7:0] RST_REFERENCE_CTRL = 8'h00;
  localparam logic RST_MODULE_STOP = 1'b0;
  localparam logic [15:0] RST_UPPER_LIMIT = 16'hFFFF;
  localparam logic [15:0] RST_LOWER_LIMIT = 16'h0000;
  localparam logic [2:0] RST_MASK = 3'h0;

  // ----------------------------------------------------------------
  // Clock select encoding, shared by target and reference fields
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_MAIN = 3'h0;
  localparam logic [2:0] SEL_SUB = 3'h1;
  localparam logic [2:0] SEL_HIGH_SPEED = 3'h2;
  localparam logic [2:0] SEL_LOW_SPEED = 3'h3;
  localparam logic [2:0] SEL_WATCHDOG = 3'h4;
  localparam logic [2:0] SEL_PERIPH_B = 3'h5;

  // ----------------------------------------------------------------
  // Filter and bus answers
  // ----------------------------------------------------------------
  localparam int unsigned FILT_LEN = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : clock_accuracy_monitor_pkg

// >>> verilog/clock_accuracy_monitor.sv
// Clock accuracy monitor: counts target clock edges per reference period over AXI4-Lite
//
// Behaviour
// - Target select: main,sub,fast,slow,watchdog,peripheral-B.
// - Reference select uses same six-code encoding.
// - External reference pin usable as reference.
// - Optional digital filter on reference path.
// - Interrupts: measurement end, frequency error, overflow.
// - Software module-stop halts measurement logic.
`timescale 1ns/100ps
`default_nettype none

module clock_accuracy_monitor
(
  // System
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  // Measured clock sources, sampled as synchronous levels
  input wire logic MAIN_CLK_I,
  input wire logic SUB_CLK_I,
  input wire logic HIGH_SPEED_INTERNAL_OSCILLATOR_I,
  input wire logic LOW_SPEED_INTERNAL_OSCILLATOR_I,
  input wire logic WATCHDOG_OSCILLATOR_CLOCK_I,
  input wire logic PERIPHERAL_CLOCK_B_I,
  input wire logic EXTERNAL_REFERENCE_INPUT_I,
  // AXI4-Lite write address
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  // AXI4-Lite write data
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  // AXI4-Lite write response
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // AXI4-Lite read address
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  // AXI4-Lite read data
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // Interrupt
  output logic IRQ_O
);

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MEAS_IDLE = 2'b00,
    MEAS_WAIT = 2'b01,
    MEAS_COUNT = 2'b10
  } meas_state_e;

  // Picks one clock level by select code; prohibited codes give a quiet 0
  function automatic logic pick_clock(input logic [2:0] sel, input logic [5:0] src);
    logic res;
    res = 1'b0;
    unique case (sel)
      clock_accuracy_monitor_pkg::SEL_MAIN: res = src[0];
      clock_accuracy_monitor_pkg::SEL_SUB: res = src[1];
      clock_accuracy_monitor_pkg::SEL_HIGH_SPEED: res = src[2];
      clock_accuracy_monitor_pkg::SEL_LOW_SPEED: res = src[3];
      clock_accuracy_monitor_pkg::SEL_WATCHDOG: res = src[4];
      clock_accuracy_monitor_pkg::SEL_PERIPH_B: res = src[5];
      default: res = 1'b0;
    endcase
    return res;
  endfunction : pick_clock

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [5:0] src_clk;
  logic [7:0] tgt_ctrl_q;
  logic [7:0] ref_ctrl_q;
  logic stop_q;
  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [15:0] count_q;
  logic [15:0] result_q;
  logic [2:0] status_q;
  logic [2:0] mask_q;
  logic [2:0] evt;
  logic [2:0] status_d;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic do_read;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_data;
  logic status_rd_clr;
  logic tgt_raw_q;
  logic tgt_prev_q;
  logic ref_raw_q;
  logic ref_prev_q;
  logic [2:0] flt_sh_q;
  logic flt_lvl_q;
  logic ref_lvl;
  logic tgt_edge;
  logic ref_edge;
  logic active;
  meas_state_e state_q;

  assign src_clk = {PERIPHERAL_CLOCK_B_I, WATCHDOG_OSCILLATOR_CLOCK_I,
                    LOW_SPEED_INTERNAL_OSCILLATOR_I, HIGH_SPEED_INTERNAL_OSCILLATOR_I,
                    SUB_CLK_I, MAIN_CLK_I};

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign do_write = !AWREADY_O && !WREADY_O && !BVALID_O;

  always_comb
  begin
    unique case (awaddr_q)
      clock_accuracy_monitor_pkg::OFS_TARGET_CTRL,
      clock_accuracy_monitor_pkg::OFS_REFERENCE_CTRL,
      clock_accuracy_monitor_pkg::OFS_MODULE_STOP,
      clock_accuracy_monitor_pkg::OFS_UPPER_LIMIT,
      clock_accuracy_monitor_pkg::OFS_LOWER_LIMIT,
      clock_accuracy_monitor_pkg::OFS_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      AWREADY_O <= 1'b1;
      WREADY_O <= 1'b1;
      BVALID_O <= 1'b0;
      BRESP_O <= clock_accuracy_monitor_pkg::RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else
    begin
      if (AWVALID_I && AWREADY_O)
      begin
        AWREADY_O <= 1'b0;
        awaddr_q <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O)
      begin
        WREADY_O <= 1'b0;
        wdata_q <= WDATA_I;
        wstrb_q <= WSTRB_I;
      end
      if (do_write)
      begin
        BVALID_O <= 1'b1;
        BRESP_O <= wr_hit ? clock_accuracy_monitor_pkg::RESP_OKAY
                          : clock_accuracy_monitor_pkg::RESP_SLVERR;
      end
      if (BVALID_O && BREADY_I)
      begin
        BVALID_O <= 1'b0;
        AWREADY_O <= 1'b1;
        WREADY_O <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      tgt_ctrl_q <= clock_accuracy_monitor_pkg::RST_TARGET_CTRL;
      ref_ctrl_q <= clock_accuracy_monitor_pkg::RST_REFERENCE_CTRL;
      stop_q <= clock_accuracy_monitor_pkg::RST_MODULE_STOP;
      upper_q <= clock_accuracy_monitor_pkg::RST_UPPER_LIMIT;
      lower_q <= clock_accuracy_monitor_pkg::RST_LOWER_LIMIT;
      mask_q <= clock_accuracy_monitor_pkg::RST_MASK;
    end
    else
    begin
      if (do_write && wstrb_q[0])
      begin
        unique case (awaddr_q)
          clock_accuracy_monitor_pkg::OFS_TARGET_CTRL: tgt_ctrl_q <= wdata_q[7:0];
          clock_accuracy_monitor_pkg::OFS_REFERENCE_CTRL: ref_ctrl_q <= wdata_q[7:0];
          clock_accuracy_monitor_pkg::OFS_MODULE_STOP:
            stop_q <= wdata_q[clock_accuracy_monitor_pkg::STOP_BIT];
          clock_accuracy_monitor_pkg::OFS_UPPER_LIMIT: upper_q[7:0] <= wdata_q[7:0];
          clock_accuracy_monitor_pkg::OFS_LOWER_LIMIT: lower_q[7:0] <= wdata_q[7:0];
          clock_accuracy_monitor_pkg::OFS_MASK: mask_q <= wdata_q[2:0];
          default: ;
        endcase
      end
      // Upper byte lane of the limits
      if (do_write && wstrb_q[1])
      begin
        if (awaddr_q == clock_accuracy_monitor_pkg::OFS_UPPER_LIMIT)
          upper_q[15:8] <= wdata_q[15:8];
        if (awaddr_q == clock_accuracy_monitor_pkg::OFS_LOWER_LIMIT)
          lower_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign do_read = ARVALID_I && ARREADY_O;
  assign status_rd_clr = do_read && (ARADDR_I == clock_accuracy_monitor_pkg::OFS_STATUS);

  always_comb
  begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (ARADDR_I)
      clock_accuracy_monitor_pkg::OFS_TARGET_CTRL: rd_data[7:0] = tgt_ctrl_q;
      clock_accuracy_monitor_pkg::OFS_REFERENCE_CTRL: rd_data[7:0] = ref_ctrl_q;
      clock_accuracy_monitor_pkg::OFS_MODULE_STOP: rd_data[0] = stop_q;
      clock_accuracy_monitor_pkg::OFS_UPPER_LIMIT: rd_data[15:0] = upper_q;
      clock_accuracy_monitor_pkg::OFS_LOWER_LIMIT: rd_data[15:0] = lower_q;
      clock_accuracy_monitor_pkg::OFS_COUNT: rd_data[15:0] = result_q;
      clock_accuracy_monitor_pkg::OFS_STATUS: rd_data[2:0] = status_q;
      clock_accuracy_monitor_pkg::OFS_MASK: rd_data[2:0] = mask_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      ARREADY_O <= 1'b1;
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0000_0000;
      RRESP_O <= clock_accuracy_monitor_pkg::RESP_OKAY;
    end
    else if (do_read)
    begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b1;
      RDATA_O <= rd_data;
      RRESP_O <= rd_hit ? clock_accuracy_monitor_pkg::RESP_OKAY
                        : clock_accuracy_monitor_pkg::RESP_SLVERR;
    end
    else if (RVALID_O && RREADY_I)
    begin
      RVALID_O <= 1'b0;
      ARREADY_O <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Clock selection, filter and edge detection
  // ----------------------------------------------------------------
  // Stop halts all measuring
  assign active = tgt_ctrl_q[clock_accuracy_monitor_pkg::TGT_EN_BIT] && !stop_q;
  assign ref_lvl = ref_ctrl_q[clock_accuracy_monitor_pkg::REF_FILT_BIT] ? flt_lvl_q
                                                                       : ref_raw_q;
  assign tgt_edge = tgt_raw_q && !tgt_prev_q;
  assign ref_edge = ref_lvl && !ref_prev_q;

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      tgt_raw_q <= 1'b0;
      tgt_prev_q <= 1'b0;
      ref_raw_q <= 1'b0;
      ref_prev_q <= 1'b0;
    end
    else
    begin
      tgt_raw_q <= pick_clock(tgt_ctrl_q[3:1], src_clk);
      tgt_prev_q <= tgt_raw_q;
      if (ref_ctrl_q[clock_accuracy_monitor_pkg::REF_EXT_BIT])
        ref_raw_q <= EXTERNAL_REFERENCE_INPUT_I;
      else
        ref_raw_q <= pick_clock(ref_ctrl_q[3:1], src_clk);
      ref_prev_q <= ref_lvl;
    end
  end

  // Filtered level follows only after the last three samples agree
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      flt_sh_q <= 3'h0;
      flt_lvl_q <= 1'b0;
    end
    else
    begin
      flt_sh_q <= {flt_sh_q[1:0], ref_raw_q};
      if (&flt_sh_q)
        flt_lvl_q <= 1'b1;
      else if (~|flt_sh_q)
        flt_lvl_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Measurement engine
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state_q <= MEAS_IDLE;
      count_q <= 16'h0000;
      result_q <= 16'h0000;
    end
    else if (!active)
    begin
      state_q <= MEAS_IDLE;
      count_q <= 16'h0000;
    end
    else
    begin
      unique case (state_q)
        MEAS_IDLE: state_q <= MEAS_WAIT;
        MEAS_WAIT:
          if (ref_edge)
          begin
            state_q <= MEAS_COUNT;
            count_q <= {15'h0000, tgt_edge};
          end
        MEAS_COUNT:
          if (ref_edge)
          begin
            result_q <= count_q;
            // A target edge on the boundary opens the new period
            count_q <= {15'h0000, tgt_edge};
          end
          else if (tgt_edge)
            count_q <= count_q + 16'h0001;
        default: state_q <= MEAS_IDLE;
      endcase
    end
  end

  // Period end, limit check and wrap
  always_comb
  begin
    evt = 3'h0;
    if (active && state_q == MEAS_COUNT)
    begin
      evt[clock_accuracy_monitor_pkg::ST_END_BIT] = ref_edge;
      evt[clock_accuracy_monitor_pkg::ST_FERR_BIT] = ref_edge &&
        ((count_q > upper_q) || (count_q < lower_q));
      evt[clock_accuracy_monitor_pkg::ST_OVF_BIT] = !ref_edge && tgt_edge &&
        (count_q == 16'hFFFF);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and output
  // ----------------------------------------------------------------
  // Sticky flags, set beats read-clear
  assign status_d = (status_rd_clr ? 3'h0 : status_q) | evt;

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      status_q <= 3'h0;
      IRQ_O <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      IRQ_O <= |(status_d & mask_q);
    end
  end

endmodule : clock_accuracy_monitor

`default_nettype wire

// >>> test/osc_bank.sv
// Oscillator bank model driving the monitor's clock inputs
`timescale 1ns/100ps
`default_nettype none
module osc_bank
(
  // System
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Clock levels: main, sub, fast, slow, watchdog, peripheral B, pin
  output logic [6:0] clk_o
);
  // Half periods in system cycles; the pin clock is offset so its edges meet only those of the fast clock
  localparam int HALF [7] = '{2, 4, 1, 20, 8, 10, 40};
  localparam int OFF [7] = '{0, 0, 0, 0, 0, 0, 1};
  int cyc_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i)
      cyc_q <= 0;
    else
      cyc_q <= cyc_q + 1;

  for (genvar i = 0; i < 7; i++)
  begin : g_clk
    assign clk_o[i] = 1'(((cyc_q + OFF[i]) / HALF[i]) % 2);
  end
endmodule : osc_bank
`default_nettype wire

// >>> test/cam_props.sv
// Bus and interrupt checker for the clock accuracy monitor
`timescale 1ns/100ps
`default_nettype none
module cam_props
(
  // System
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  // Write side
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic [1:0] BRESP_O,
  input wire logic BVALID_O,
  input wire logic BREADY_I,
  // Read side
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic [31:0] RDATA_O,
  input wire logic [1:0] RRESP_O,
  input wire logic RVALID_O,
  input wire logic RREADY_I,
  // Interrupt
  input wire logic IRQ_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  logic [3:0] quiet_q;

  // Cycles since the last bus answer
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
    if (!RSTN_I)
      quiet_q <= 4'h0;
    else if ((ARVALID_I && ARREADY_O) || RVALID_O || BVALID_O)
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hF)
      quiet_q <= quiet_q + 4'h1;

  sequence w_take;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  endsequence
  sequence r_take;
    ARVALID_I && ARREADY_O;
  endsequence

  a_write_answer: assert property (w_take |=> !AWREADY_O && !BVALID_O ##1 BVALID_O)
    else $error("write answer late or early");
  a_read_answer: assert property (r_take |=> RVALID_O && !ARREADY_O)
    else $error("read answer missing");
  a_read_stands: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read data dropped");
  a_resp_stands: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write response dropped");
  a_read_release: assert property (RVALID_O && RREADY_I |=> !RVALID_O && ARREADY_O)
    else $error("read channel not released");
  a_unmapped_err: assert property (r_take and ARADDR_I > 8'h1C |=>
    RRESP_O == clock_accuracy_monitor_pkg::RESP_SLVERR && RDATA_O == 32'h0)
    else $error("unmapped read not refused");
  a_irq_clear: assert property ($fell(IRQ_O) |-> quiet_q <= 4'h3)
    else $error("interrupt fell without a bus access");
endmodule : cam_props
bind clock_accuracy_monitor cam_props cam_props_inst (.*);
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the clock accuracy monitor
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [7:0] A_TGT = clock_accuracy_monitor_pkg::OFS_TARGET_CTRL;
  localparam logic [7:0] A_REF = clock_accuracy_monitor_pkg::OFS_REFERENCE_CTRL;
  localparam logic [7:0] A_STOP = clock_accuracy_monitor_pkg::OFS_MODULE_STOP;
  localparam logic [7:0] A_UP = clock_accuracy_monitor_pkg::OFS_UPPER_LIMIT;
  localparam logic [7:0] A_LO = clock_accuracy_monitor_pkg::OFS_LOWER_LIMIT;
  localparam logic [7:0] A_CNT = clock_accuracy_monitor_pkg::OFS_COUNT;
  localparam logic [7:0] A_ST = clock_accuracy_monitor_pkg::OFS_STATUS;
  localparam logic [7:0] A_MSK = clock_accuracy_monitor_pkg::OFS_MASK;
  localparam logic [1:0] OK = clock_accuracy_monitor_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = clock_accuracy_monitor_pkg::RESP_SLVERR;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, st;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [6:0] osc;
  int failures, total_checks;

  osc_bank osc_bank_inst (.clk_i(clk), .rst_n_i(rst_n), .clk_o(osc));
  clock_accuracy_monitor clock_accuracy_monitor_inst (.CLK_SYS_I(clk), .RSTN_I(rst_n),
    .MAIN_CLK_I(osc[0]), .SUB_CLK_I(osc[1]), .HIGH_SPEED_INTERNAL_OSCILLATOR_I(osc[2]),
    .LOW_SPEED_INTERNAL_OSCILLATOR_I(osc[3]), .WATCHDOG_OSCILLATOR_CLOCK_I(osc[4]),
    .PERIPHERAL_CLOCK_B_I(osc[5]), .EXTERNAL_REFERENCE_INPUT_I(osc[6]),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
    .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
    .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
    .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
    .RREADY_I(rready), .IRQ_O(irq));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge clk);
      if (awready) ta = 1'b1;
      if (wready) tw = 1'b1;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("write resp", {30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [1:0] r;
    rd(a, st, r);
    chk("read data", st, exp);
    chk("read resp", {30'h0, r}, {30'h0, er});
  endtask : rc

  task automatic wait_end();
    logic [1:0] r;
    st = 32'h0;
    while (st[0] !== 1'b1) rd(A_ST, st, r);
  endtask : wait_end

  task automatic meas(input logic [31:0] t, input logic [31:0] r, input logic [31:0] exp);
    logic [1:0] rs;
    wr(A_TGT, 32'h0, OK);
    wr(A_REF, r, OK);
    // Drop flags left from the previous setting
    rd(A_ST, st, rs);
    wr(A_TGT, t, OK);
    wait_end();
    wait_end();
    rc(A_CNT, exp, OK);
  endtask : meas

  task automatic t_reset();
    logic [31:0] e [8] = '{32'h0, 32'h0, 32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++)
      rc(8'(i * 4), e[i], OK);
    rc(8'h20, 32'h0, ERR);
    wr(A_CNT, 32'h5, ERR);
    wr(8'h24, 32'h5, ERR);
  endtask : t_reset

  task automatic t_target();
    logic [31:0] e [7] = '{32'h14, 32'hA, 32'h28, 32'h2, 32'h5, 32'h4, 32'h0};
    for (int i = 0; i < 7; i++)
      meas(32'(i * 2 + 1), 32'h1, e[i]);
  endtask : t_target

  task automatic t_ref();
    logic [31:0] e [6] = '{32'h2, 32'h4, 32'h1, 32'h14, 32'h8, 32'hA};
    for (int i = 0; i < 6; i++)
      meas(32'h5, 32'(i * 2), e[i]);
  endtask : t_ref

  task automatic t_ferr();
    wr(A_LO, 32'h19, OK);
    wr(A_MSK, 32'h2, OK);
    meas(32'h1, 32'h11, 32'h14);
    wait_end();
    chk("status low", st, 32'h3);
    repeat (200) if (irq !== 1'b1) @(posedge clk);
    chk("irq set", {31'h0, irq}, 32'h1);
    wr(A_MSK, 32'h0, OK);
    repeat (3) @(posedge clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(A_LO, 32'h0, OK);
    wr(A_UP, 32'h13, OK);
    wait_end();
    wait_end();
    chk("status high", st, 32'h3);
    // Upper byte lane only
    wstrb <= 4'h2;
    wr(A_UP, 32'hFFFF, OK);
    rc(A_UP, 32'hFF13, OK);
    wstrb <= 4'hF;
    wr(A_UP, 32'hFFFF, OK);
  endtask : t_ferr

  task automatic t_stop();
    logic [1:0] r;
    wr(A_STOP, 32'h1, OK);
    rd(A_ST, st, r);
    repeat (300) @(posedge clk);
    rc(A_ST, 32'h0, OK);
    wr(A_STOP, 32'h0, OK);
    wait_end();
    wait_end();
    rc(A_CNT, 32'h14, OK);
  endtask : t_stop

  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    results();
  end

  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_target();
    t_ref();
    t_ferr();
    t_stop();
    results();
  end
endmodule : testbench
`default_nettype wire
